// ---- design/flash_status_host.sv ----
// Behaviour
// RQ1 - host resumes a suspended sector erase by writing the resume command
// RQ2 - device ignores repeated resume, accepts a later suspend
// RQ3 - device runs identification sequence in erase-suspend-read mode
// RQ4 - data-poll bit valid from last write strobe rising edge
// RQ5 - program read shows inverted bit until done, then true bit
// RQ6 - protected program address: busy about 250ns, then array reads
// RQ7 - erase shows data-poll bit 0, then 1 when done or suspended
// RQ8 - host polls at program address, or in a sector being erased
// RQ9 - all selected sectors protected: busy about 1.8us, no erase
// RQ10 - partly protected erase skips protected sectors, their status unreliable
// RQ11 - host re-reads data-poll bit even after timing-limit bit sets
// RQ12 - open-drain ready/busy low while erasing or programming
// RQ13 - ready/busy valid from final write strobe rising edge
// RQ14 - toggle bit one inverts every read while busy
// RQ15 - toggle bit one valid from final write strobe, incl time-out
// RQ16 - toggle bit one stops on suspend, toggles during suspended program
// RQ17 - toggle bit two inverts on reads inside erase-selected sectors
// RQ18 - host starts toggle polling with two back-to-back reads and compares
// RQ19 - still toggling: check timing limit, retest, reset on failure
// RQ20 - host returning to polling restarts from the first read pair
// RQ21 - timing-limit bit reads 1 on pulse-limit overrun; halts till reset
// RQ22 - erase timer bit 0 while accepting sectors, 1 once erase starts
// RQ23 - suspend code is B0h, honoured only in sector erase
// RQ24 - resume command code is a configurable constant
// RQ25 - device returns status byte instead of array data while busy
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module flash_status_host
    import flash_host_pkg::*;
(
    // clock and reset
    input logic CORE_CLK,
    input logic ARST_N,
    // axi4-lite write address and data
    input logic [7:0] AWADDR,
    input logic AWVALID,
    output logic AWREADY,
    input logic [31:0] WDATA,
    input logic [3:0] WSTRB,
    input logic WVALID,
    output logic WREADY,
    // axi4-lite write response
    output logic [1:0] BRESP,
    output logic BVALID,
    input logic BREADY,
    // axi4-lite read
    input logic [7:0] ARADDR,
    input logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input logic RREADY,
    // flash pins
    output logic CE_N,
    output logic OE_N,
    output logic WE_N,
    output logic [FA_W-1:0] FLASH_ADDR,
    input logic [7:0] DQ_I,
    output logic [7:0] DQ_O,
    output logic DQ_OE,
    input logic READY_BUSY_N
);

    typedef enum logic [3:0] {
        S_IDLE, S_CMD, S_READ, S_T1, S_T2, S_T3, S_P1, S_P2, S_RST
    } mst_t;

    typedef struct packed {
        mst_t st;
        logic [FA_W-1:0] addr;
        logic [7:0] wdata;
        logic [7:0] cmd;
        logic [7:0] resume;
        logic sel_two;
        logic done;
        res_t result;
        logic [7:0] rdata;
        logic prev;
        logic tl_seen;
        logic abort;
        logic rb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rd;
        logic [1:0] rresp;
    } hst_t;

    localparam hst_t Q_RST = '{st: S_IDLE, result: RES_NONE,
        resume: RESUME_RST, rb: 1'b1, default: '0};

    function automatic logic [31:0] wmask(logic [31:0] old,
                                          logic [31:0] nw,
                                          logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    hst_t q, d;
    logic wr_go;
    logic rd_go;

    flash_cyc_if cyc ();

    flash_cycle u_cycle (
        .clk(CORE_CLK),
        .arst_n(ARST_N),
        .cyc(cyc.slave),
        .ce_n(CE_N),
        .oe_n(OE_N),
        .we_n(WE_N),
        .fa(FLASH_ADDR),
        .dq_i(DQ_I),
        .dq_o(DQ_O),
        .dq_oe(DQ_OE)
    );

    assign wr_go = AWVALID && WVALID && !q.bvalid;
    assign rd_go = ARVALID && !q.rvalid;

    always_comb begin
        logic [31:0] m;
        logic tbit;
        logic tlim;
        logic finish;
        logic clr_done;
        res_t res;
        m = '0;
        tbit = 1'b0;
        tlim = 1'b0;
        finish = 1'b0;
        clr_done = 1'b0;
        res = RES_NONE;
        d = q;
        // pin is sampled on every core clock, during our own bus cycles as well [RQ13]
        d.rb = READY_BUSY_N; // [RQ12]

        // register writes
        if (q.bvalid && BREADY) begin
            d.bvalid = 1'b0;
        end
        if (wr_go) begin
            d.bvalid = 1'b1;
            d.bresp = RESP_OKAY;
            unique case (AWADDR)
                CTRL_OFS: begin
                    if (WSTRB[0] && q.st == S_IDLE) begin
                        d.result = RES_NONE;
                        d.tl_seen = 1'b0;
                        d.abort = 1'b0;
                        unique case (op_t'(WDATA[2:0]))
                            OP_NONE: d.st = S_IDLE;
                            OP_WRITE: begin
                                d.cmd = q.wdata;
                                d.st = S_CMD;
                            end
                            OP_READ: d.st = S_READ;
                            // toggle polling always opens with a fresh pair [RQ20]
                            OP_TOGGLE: d.st = S_T1;
                            OP_POLL: d.st = S_P1;
                            OP_SUSPEND: begin
                                d.cmd = CMD_SUSPEND; // [RQ23]
                                d.st = S_CMD;
                            end
                            OP_RESUME: begin
                                d.cmd = q.resume; // [RQ1] [RQ24]
                                d.st = S_CMD;
                            end
                            OP_RESET: begin
                                d.cmd = CMD_RESET;
                                d.st = S_CMD;
                            end
                        endcase
                    end
                    if (WSTRB[0] && WDATA[CTRL_ABORT_POS]
                        && q.st != S_IDLE) begin
                        d.abort = 1'b1; // [RQ20]
                    end
                end
                ADDR_OFS: begin
                    m = wmask(32'(q.addr), WDATA, WSTRB);
                    d.addr = m[FA_W-1:0]; // [RQ8]
                end
                WDATA_OFS: begin
                    m = wmask(32'(q.wdata), WDATA, WSTRB);
                    d.wdata = m[7:0];
                end
                CFG_OFS: begin
                    m = wmask({23'h0, q.sel_two, q.resume}, WDATA, WSTRB);
                    d.resume = m[7:0]; // [RQ24]
                    d.sel_two = m[CFG_SEL_POS]; // [RQ17]
                end
                STATUS_OFS: begin
                    clr_done = WSTRB[0] && WDATA[ST_DONE_POS];
                end
                default: d.bresp = RESP_DECERR;
            endcase
        end

        // register reads
        if (q.rvalid && RREADY) begin
            d.rvalid = 1'b0;
        end
        if (rd_go) begin
            d.rvalid = 1'b1;
            d.rresp = RESP_OKAY;
            unique case (ARADDR)
                CTRL_OFS: d.rd = 32'(q.st);
                ADDR_OFS: d.rd = 32'(q.addr);
                WDATA_OFS: d.rd = 32'(q.wdata);
                CFG_OFS: d.rd = {23'h0, q.sel_two, q.resume};
                STATUS_OFS: begin
                    d.rd = '0;
                    d.rd[ST_BUSY_POS] = (q.st != S_IDLE);
                    d.rd[ST_DONE_POS] = q.done;
                    d.rd[ST_RES_POS +: 2] = q.result;
                    d.rd[ST_RB_POS] = q.rb;
                    d.rd[ST_DATA_POS +: 8] = q.rdata;
                    d.rd[ST_TL_POS] = q.tl_seen;
                end
                default: begin
                    d.rd = '0;
                    d.rresp = RESP_DECERR;
                end
            endcase
        end

        // polling engine, advanced once per finished bus cycle
        tbit = q.sel_two ? cyc.rdata[TOGGLE_TWO_POS]
                         : cyc.rdata[TOGGLE_ONE_POS];
        tlim = cyc.rdata[TIMING_LIMIT_POS]; // [RQ21]
        if (cyc.done) begin
            d.rdata = cyc.rdata;
            unique case (q.st)
                S_IDLE: d.st = S_IDLE;
                S_CMD: begin
                    finish = 1'b1;
                    res = RES_PASS;
                end
                S_READ: begin
                    finish = 1'b1;
                    res = RES_PASS;
                end
                S_T1: begin
                    d.prev = tbit; // [RQ18]
                    d.st = S_T2;
                end
                S_T2: begin
                    d.prev = tbit;
                    if (tbit == q.prev) begin
                        finish = 1'b1; // [RQ18]
                        res = RES_PASS;
                    end else if (tlim) begin
                        d.tl_seen = 1'b1;
                        d.st = S_T3; // [RQ19]
                    end
                end
                S_T3: begin
                    if (tbit == q.prev) begin
                        finish = 1'b1;
                        res = RES_PASS;
                    end else begin
                        d.st = S_RST; // [RQ19]
                    end
                end
                S_P1: begin
                    // expected bit is bit 7 of the written byte in wdata, for erase as for program
                    if (cyc.rdata[DATA_POLL_POS] == q.wdata[DATA_POLL_POS])
                    begin
                        finish = 1'b1; // [RQ5] [RQ7]
                        res = RES_PASS;
                    end else if (tlim) begin
                        d.tl_seen = 1'b1;
                        d.st = S_P2; // [RQ11]
                    end
                end
                S_P2: begin
                    // the poll bit may flip just as the limit bit sets
                    if (cyc.rdata[DATA_POLL_POS] == q.wdata[DATA_POLL_POS])
                    begin
                        finish = 1'b1; // [RQ11]
                        res = RES_PASS;
                    end else begin
                        d.st = S_RST;
                    end
                end
                S_RST: begin
                    finish = 1'b1; // [RQ19]
                    res = RES_FAIL;
                end
            endcase
            // abort waits for the running pin cycle to close cleanly
            if (q.abort && !finish) begin
                finish = 1'b1;
                res = RES_ABORT;
            end
        end
        if (finish) begin
            d.st = S_IDLE;
            d.result = res;
            d.abort = 1'b0;
        end
        // a finish in the clearing cycle keeps the flag set
        d.done = finish || (q.done && !clr_done);
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            q <= Q_RST;
        end else begin
            q <= d;
        end
    end

    // bus cycle requests
    assign cyc.req = (q.st != S_IDLE);
    assign cyc.wr = (q.st == S_CMD) || (q.st == S_RST);
    assign cyc.wdata = (q.st == S_RST) ? CMD_RESET : q.cmd;
    assign cyc.addr = q.addr;

    // axi4-lite handshakes
    assign AWREADY = wr_go;
    assign WREADY = wr_go;
    assign BVALID = q.bvalid;
    assign BRESP = q.bresp;
    assign ARREADY = !q.rvalid;
    assign RVALID = q.rvalid;
    assign RDATA = q.rd;
    assign RRESP = q.rresp;

endmodule // flash_status_host

// ---- design/flash_host_pkg.sv ----
package flash_host_pkg;

    // core clock
    localparam int CLK_NS = 10;

    // least times of one bus cycle on the flash pins
    localparam int T_ACC_NS = 70;
    localparam int T_WP_NS = 40;
    localparam int T_HOLD_NS = 20;

    function automatic int cyc_min(int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam logic [3:0] ACC_CYC = 4'(cyc_min(T_ACC_NS));
    localparam logic [3:0] WP_CYC = 4'(cyc_min(T_WP_NS));
    localparam logic [3:0] HOLD_CYC = 4'(cyc_min(T_HOLD_NS));

    // flash address width
    localparam int FA_W = 20;

    // command codes
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_RESET = 8'hF0;
    localparam logic [7:0] RESUME_RST = 8'h30;

    // status byte layout
    localparam int DATA_POLL_POS = 7;
    localparam int TOGGLE_ONE_POS = 6;
    localparam int TIMING_LIMIT_POS = 5;
    localparam int ERASE_TIMER_POS = 3;
    localparam int TOGGLE_TWO_POS = 2;

    // register offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] ADDR_OFS = 8'h04;
    localparam logic [7:0] WDATA_OFS = 8'h08;
    localparam logic [7:0] CFG_OFS = 8'h0C;
    localparam logic [7:0] STATUS_OFS = 8'h10;

    // field positions
    localparam int CTRL_ABORT_POS = 3;
    localparam int CFG_SEL_POS = 8;
    localparam int ST_BUSY_POS = 0;
    localparam int ST_DONE_POS = 1;
    localparam int ST_RES_POS = 2;
    localparam int ST_RB_POS = 4;
    localparam int ST_DATA_POS = 8;
    localparam int ST_TL_POS = 16;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [2:0] {
        OP_NONE, OP_WRITE, OP_READ, OP_TOGGLE,
        OP_POLL, OP_SUSPEND, OP_RESUME, OP_RESET
    } op_t;

    typedef enum logic [1:0] {
        RES_NONE, RES_PASS, RES_FAIL, RES_ABORT
    } res_t;

endpackage

// ---- design/flash_cyc_if.sv ----
`timescale 1ns/1ps
interface flash_cyc_if;
    import flash_host_pkg::*;
    logic req;
    logic wr;
    logic [FA_W-1:0] addr;
    logic [7:0] wdata;
    logic done;
    logic [7:0] rdata;

    modport master (output req, wr, addr, wdata, input done, rdata);
    modport slave (input req, wr, addr, wdata, output done, rdata);
endinterface

// ---- design/flash_cycle.sv ----
`timescale 1ns/1ps
module flash_cycle
    import flash_host_pkg::*;
(
    // clock and reset
    input logic clk,
    input logic arst_n,
    // request side
    flash_cyc_if.slave cyc,
    // flash pins
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic [FA_W-1:0] fa,
    input logic [7:0] dq_i,
    output logic [7:0] dq_o,
    output logic dq_oe
);

    typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} cst_t;

    typedef struct packed {
        cst_t st;
        logic wr;
        logic [3:0] cnt;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic oe;
        logic [FA_W-1:0] fa;
        logic [7:0] dq;
        logic [7:0] rd;
        logic done;
    } cyc_t;

    localparam cyc_t C_RST = '{st: C_IDLE, ce_n: 1'b1, oe_n: 1'b1,
        we_n: 1'b1, default: '0};

    cyc_t q, d;

    always_comb begin
        d = q;
        d.done = 1'b0;
        unique case (q.st)
            C_IDLE: begin
                // the done cycle still sees the old request, so skip it
                if (cyc.req && !q.done) begin
                    d.st = C_SETUP;
                    d.wr = cyc.wr;
                    d.fa = cyc.addr;
                    d.dq = cyc.wdata;
                    d.oe = cyc.wr;
                    d.ce_n = 1'b0;
                end
            end
            C_SETUP: begin
                d.st = C_STROBE;
                d.oe_n = q.wr;
                d.we_n = !q.wr;
                d.cnt = q.wr ? WP_CYC : ACC_CYC;
            end
            C_STROBE: begin
                d.cnt = q.cnt - 4'h1;
                if (q.cnt == 4'h1) begin
                    d.st = C_HOLD;
                    d.rd = q.wr ? q.rd : dq_i;
                    d.oe_n = 1'b1;
                    d.we_n = 1'b1;
                    d.cnt = HOLD_CYC;
                end
            end
            C_HOLD: begin
                // chip select high ends each read cycle on its own [RQ14]
                d.cnt = q.cnt - 4'h1;
                if (q.cnt == 4'h1) begin
                    d.st = C_IDLE;
                    d.ce_n = 1'b1;
                    d.oe = 1'b0;
                    d.done = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= C_RST;
        end else begin
            q <= d;
        end
    end

    assign cyc.done = q.done;
    assign cyc.rdata = q.rd;
    assign ce_n = q.ce_n;
    assign oe_n = q.oe_n;
    assign we_n = q.we_n;
    assign fa = q.fa;
    assign dq_o = q.dq;
    assign dq_oe = q.oe;

endmodule // flash_cycle

// ---- dv/flash_status_host_properties.sv ----
`timescale 1ns/1ps
module flash_status_host_checker
    import flash_host_pkg::*;
(
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    // register bus
    input wire logic AWVALID,
    input wire logic WVALID,
    input wire logic AWREADY,
    input wire logic [1:0] BRESP,
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    input wire logic [31:0] RDATA,
    input wire logic [1:0] RRESP,
    input wire logic RVALID,
    input wire logic RREADY,
    // flash pins
    input wire logic CE_N,
    input wire logic OE_N,
    input wire logic WE_N,
    input wire logic DQ_OE
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);

    // strobe, then hold with the chip still selected
    sequence rd_strobe;
        !OE_N [*7] ##1 (OE_N && !CE_N) [*2] ##1 CE_N;
    endsequence
    sequence wr_strobe;
        !WE_N [*4] ##1 (WE_N && !CE_N) [*2] ##1 CE_N;
    endsequence

    wr_answer_a: assert property (AWVALID && WVALID && !BVALID |=> BVALID)
        else $error("write not answered");
    wr_refuse_a: assert property (BVALID |-> !AWREADY)
        else $error("write taken while answer pending");
    wr_stand_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write answer dropped early");
    rd_answer_a: assert property (ARVALID && !RVALID |=> RVALID)
        else $error("read not answered");
    rd_stand_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read answer dropped early");
    rd_unmapped_a: assert property (ARVALID && !RVALID && ARADDR > STATUS_OFS
        |=> RRESP == RESP_DECERR && RDATA == 32'h0)
        else $error("unmapped read not refused");
    read_cycle_a: assert property ($fell(OE_N) |-> rd_strobe)
        else $error("read strobe shape wrong");
    write_cycle_a: assert property ($fell(WE_N) |-> wr_strobe)
        else $error("write strobe shape wrong");
    select_first_a: assert property ($fell(OE_N) || $fell(WE_N)
        |-> !$past(CE_N))
        else $error("strobe without chip select");
    cycle_gap_a: assert property ($rose(CE_N) |-> CE_N [*2])
        else $error("cycles too close");
    no_contend_a: assert property (DQ_OE |-> OE_N)
        else $error("host drives while flash outputs");
endmodule // flash_status_host_checker

bind flash_status_host flash_status_host_checker u_chk (
    .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .AWVALID(AWVALID),
    .WVALID(WVALID), .AWREADY(AWREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .RDATA(RDATA),
    .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .CE_N(CE_N),
    .OE_N(OE_N), .WE_N(WE_N), .DQ_OE(DQ_OE)
);

// ---- dv/flash_dev_model.sv ----
`timescale 1ns/1ps
module flash_dev_model
    import flash_host_pkg::*;
(
    // flash pins
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [7:0] dq_o,
    output logic [7:0] dq_i,
    output logic ready_busy_n,
    // scenario controls
    input wire logic erase,
    input wire logic halt,
    input wire logic [31:0] busy_len,
    input wire logic prot
);
    int left = 0;
    logic susp = 1'b0;
    logic tog = 1'b0;
    logic tog2 = 1'b0;
    logic [7:0] prog = 8'hFF;
    logic [7:0] last = 8'h00;
    logic [7:0] stat;
    logic busy;

    // read cycles are the unit of progress, so no device clock is needed
    assign busy = (left > 0) && !susp;
    assign ready_busy_n = !busy;
    // a released bus has no keeper: show the inverse of the last byte
    assign dq_i = (!ce_n && !oe_n) ? stat : ~last;

    always_comb begin
        stat = prog;
        if (busy || susp) begin
            stat[7] = erase ? susp : ~prog[7];
            stat[6] = tog;
            stat[5] = halt && busy;
            stat[3] = erase;
            stat[2] = tog2;
        end
    end

    always @(posedge oe_n) begin
        if (!ce_n) begin
            last = stat;
            if (busy) tog = ~tog;
            if (erase && (busy || susp)) tog2 = ~tog2;
            if (busy && !halt) left = left - 1;
        end
    end

    always @(posedge we_n) begin
        if (!ce_n) begin
            if (dq_o == CMD_RESET) begin
                left = 0;
                susp = 1'b0;
            end else if (dq_o == CMD_SUSPEND) begin
                susp = erase && (left > 0);
            end else if (dq_o == RESUME_RST) begin
                susp = 1'b0;
            end else if (!busy && !susp) begin
                // a protected target only shows busy briefly, nothing lands
                if (!prot) prog = dq_o;
                left = prot ? 2 : busy_len;
            end
        end
    end
endmodule // flash_dev_model

// ---- dv/test_flash_status_host.sv ----
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin err_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module test_flash_status_host
    import flash_host_pkg::*;
;
    logic clk, arst_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, ce_n, oe_n, we_n, dq_oe;
    logic rb_n, erase, halt, prot;
    logic [7:0] awaddr, araddr, dq_i, dq_o;
    logic [31:0] wdata, rdata, d, busy_len;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [FA_W-1:0] fa;
    int err_count = 0;
    int checked = 0;

    flash_status_host uut (.CORE_CLK(clk), .ARST_N(arst_n),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
        .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
        .RVALID(rvalid), .RREADY(rready), .CE_N(ce_n), .OE_N(oe_n),
        .WE_N(we_n), .FLASH_ADDR(fa), .DQ_I(dq_i), .DQ_O(dq_o),
        .DQ_OE(dq_oe), .READY_BUSY_N(rb_n));
    flash_dev_model dev (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .dq_o(dq_o), .dq_i(dq_i), .ready_busy_n(rb_n), .erase(erase),
        .halt(halt), .busy_len(busy_len), .prot(prot));

    task automatic stop_test();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic tick(inout int n);
        @(posedge clk);
        n++;
        if (n > 3000) begin
            `CHK("timeout", 1'b0, 1'b1)
            stop_test();
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        int n = 0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do tick(n); while (awready !== 1'b1);
        `CHK("wready", 1'b1, wready)
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b1;
        do tick(n); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a);
        int n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do tick(n); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do tick(n); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // a poll that never settles is stopped once the engine shows busy
    task automatic run(input op_t op, input logic abort);
        int n = 0;
        axi_wr(CTRL_OFS, {29'h0, op});
        if (abort) begin
            do begin
                axi_rd(STATUS_OFS);
                tick(n);
            end while (d[ST_BUSY_POS] !== 1'b1);
            axi_wr(CTRL_OFS, 32'h1 << CTRL_ABORT_POS);
        end
        do begin
            axi_rd(STATUS_OFS);
            tick(n);
        end while (d[ST_DONE_POS] !== 1'b1);
        axi_wr(STATUS_OFS, 32'h1 << ST_DONE_POS);
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        arst_n = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, erase, halt, prot} = '0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hF;
        busy_len = 32'h3;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        axi_rd(CFG_OFS);
        `CHK("cfg reset", 32'h30, d)
        axi_rd(STATUS_OFS);
        `CHK("status reset", 32'h10, d)
        axi_rd(8'h40);
        `CHK("unmapped read", RESP_DECERR, r)
        axi_wr(8'h40, 32'h0);
        `CHK("unmapped write", RESP_DECERR, r)
        axi_wr(ADDR_OFS, 32'hFFFF_FFFF);
        axi_rd(ADDR_OFS);
        `CHK("addr width", 32'h000F_FFFF, d)
        axi_wr(WDATA_OFS, 32'hA5);
        run(OP_WRITE, 1'b0);
        `CHK("busy pin", 1'b0, d[ST_RB_POS])
        run(OP_POLL, 1'b0);
        `CHK("poll pass", RES_PASS, d[ST_RES_POS +: 2])
        `CHK("array byte", 8'hA5, d[ST_DATA_POS +: 8])
        `CHK("ready pin", 1'b1, d[ST_RB_POS])
        run(OP_WRITE, 1'b0);
        run(OP_TOGGLE, 1'b0);
        `CHK("toggle pass", RES_PASS, d[ST_RES_POS +: 2])
        prot <= 1'b1;
        axi_wr(WDATA_OFS, 32'h5A);
        run(OP_WRITE, 1'b0);
        run(OP_TOGGLE, 1'b0);
        run(OP_READ, 1'b0);
        `CHK("protected kept", 8'hA5, d[ST_DATA_POS +: 8])
        `CHK("flash addr", 20'hF_FFFF, fa)
        prot <= 1'b0;
        halt <= 1'b1;
        run(OP_WRITE, 1'b0);
        run(OP_TOGGLE, 1'b0);
        `CHK("limit fail", RES_FAIL, d[ST_RES_POS +: 2])
        `CHK("limit seen", 1'b1, d[ST_TL_POS])
        run(OP_WRITE, 1'b0);
        run(OP_POLL, 1'b0);
        `CHK("poll limit fail", RES_FAIL, d[ST_RES_POS +: 2])
        halt <= 1'b0;
        busy_len <= 32'd1000;
        run(OP_WRITE, 1'b0);
        run(OP_SUSPEND, 1'b0);
        `CHK("program no suspend", 1'b0, d[ST_RB_POS])
        run(OP_RESET, 1'b0);
        erase <= 1'b1;
        axi_wr(WDATA_OFS, 32'h00);
        run(OP_WRITE, 1'b0);
        run(OP_POLL, 1'b0);
        `CHK("erase poll", RES_PASS, d[ST_RES_POS +: 2])
        run(OP_SUSPEND, 1'b0);
        axi_wr(WDATA_OFS, 32'h80);
        run(OP_POLL, 1'b0);
        `CHK("suspend poll", RES_PASS, d[ST_RES_POS +: 2])
        `CHK("suspend ready", 1'b1, d[ST_RB_POS])
        run(OP_TOGGLE, 1'b0);
        `CHK("toggle one stops", RES_PASS, d[ST_RES_POS +: 2])
        axi_wr(CFG_OFS, 32'h130);
        run(OP_TOGGLE, 1'b1);
        `CHK("toggle two", RES_ABORT, d[ST_RES_POS +: 2])
        run(OP_RESUME, 1'b0);
        `CHK("resumed", 1'b0, d[ST_RB_POS])
        run(OP_RESUME, 1'b0);
        `CHK("resume again", 1'b0, d[ST_RB_POS])
        run(OP_SUSPEND, 1'b0);
        `CHK("suspend again", 1'b1, d[ST_RB_POS])
        run(OP_RESET, 1'b0);
        `CHK("after reset", 1'b1, d[ST_RB_POS])
        stop_test();
    end
endmodule // test_flash_status_host
